// file: core/atm_track_ctrl.sv
// Purpose: Track-and-hold sequencing and input mux selection for the 8-bit converter.
// Assumes: Register write strobe on the same clock; start pin is asynchronous.
// Notes: Sample/compare analogue path is outside; this block issues controls and builds the SAR result from comp_in.
module atm_track_ctrl (
    input wire logic clk,
    input wire logic rst,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic lowpower_track_select,
    input wire logic use_ext_start,
    input wire logic sw_start,
    input wire logic external_convert_start,
    input wire logic standby,
    input wire logic [7:0] sar_div,
    input wire logic comp_in,
    output logic track_en,
    output logic busy,
    output logic done,
    output logic [7:0] result,
    output atm_pkg::atm_neg_sel_t neg_sel,
    output atm_pkg::atm_pos_sel_t pos_sel
);
    // Channel select register, written by software and read back unchanged.
    logic [7:0] chsel_r;
    logic [7:0] chsel_nxt;

    // Start pin synchroniser and rising-edge detector.
    logic [1:0] pin_sync_r;
    logic [1:0] pin_sync_nxt;
    logic pin_prev_r;
    logic pin_prev_nxt;

    // Sequencer state, SAR clock divider and step counter.
    atm_pkg::atm_state_t st_r;
    atm_pkg::atm_state_t st_nxt;
    logic [7:0] div_r;
    logic [7:0] div_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic [7:0] sar_r;
    logic [7:0] sar_nxt;
    logic [7:0] res_r;
    logic [7:0] res_nxt;
    logic done_r;
    logic done_nxt;

    // Successive approximation accumulator.
    logic [7:0] approx_r;
    logic [7:0] approx_nxt;

    logic tick;
    logic pin_rise;
    logic start;
    logic bit_step;
    logic conv_enter;

    // Register group.
    always_comb begin
        chsel_nxt = chsel_r;
        if (sfr_wr && sfr_addr == atm_pkg::CHSEL_ADDR) begin
            chsel_nxt = sfr_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            chsel_r <= atm_pkg::CHSEL_RESET;
        end else begin
            chsel_r <= chsel_nxt;
        end
    end

    assign sfr_rdata = (sfr_addr == atm_pkg::CHSEL_ADDR) ? chsel_r : 8'h00;

    // Pin synchroniser group.
    // The pin idles high, so these flops reset high and no false edge follows reset.
    always_comb begin
        pin_sync_nxt = {pin_sync_r[0], external_convert_start};
        pin_prev_nxt = pin_sync_r[1];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pin_sync_r <= 2'b11;
            pin_prev_r <= 1'b1;
        end else begin
            pin_sync_r <= pin_sync_nxt;
            pin_prev_r <= pin_prev_nxt;
        end
    end

    assign pin_rise = pin_sync_r[1] && !pin_prev_r;
    assign start = use_ext_start ? pin_rise : sw_start;
    assign tick = (div_r == 8'h00);

    // A bit decision is made on each of the first eight SAR clocks of a conversion.
    assign bit_step = (st_r == atm_pkg::ATM_CONV) && tick && (cnt_r > 4'h2);

    // Sequencer group.
    always_comb begin
        st_nxt = st_r;
        div_nxt = (tick || st_r == atm_pkg::ATM_IDLE) ? sar_div : div_r - 8'h01;
        cnt_nxt = cnt_r;
        sar_nxt = sar_r;
        res_nxt = res_r;
        done_nxt = 1'b0;
        case (st_r)
            atm_pkg::ATM_IDLE: begin
                if (start && !standby) begin
                    if (lowpower_track_select && !use_ext_start) begin
                        st_nxt = atm_pkg::ATM_TRACK;
                        cnt_nxt = 4'(atm_pkg::TRACK_SAR_CLKS - 1);
                    end else begin
                        st_nxt = atm_pkg::ATM_CONV;
                        cnt_nxt = 4'(atm_pkg::CONV_SAR_CLKS - 1);
                        sar_nxt = 8'h80;
                    end
                end
            end
            atm_pkg::ATM_TRACK: begin
                if (tick) begin
                    if (cnt_r == 4'h0) begin
                        st_nxt = atm_pkg::ATM_CONV;
                        cnt_nxt = 4'(atm_pkg::CONV_SAR_CLKS - 1);
                        sar_nxt = 8'h80;
                    end else begin
                        cnt_nxt = cnt_r - 4'h1;
                    end
                end
            end
            atm_pkg::ATM_CONV: begin
                if (tick) begin
                    // bit decisions in the first 8 SAR clocks, then settle.
                    if (bit_step) begin
                        sar_nxt = sar_r >> 1;
                    end
                    if (cnt_r == 4'h0) begin
                        st_nxt = atm_pkg::ATM_IDLE;
                        done_nxt = 1'b1;
                        res_nxt = approx_r;
                    end else begin
                        cnt_nxt = cnt_r - 4'h1;
                    end
                end
            end
            default: st_nxt = atm_pkg::ATM_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= atm_pkg::ATM_IDLE;
            div_r <= atm_pkg::SAR_DIV_RESET;
            cnt_r <= 4'h0;
            sar_r <= 8'h00;
            res_r <= 8'h00;
            done_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            div_r <= div_nxt;
            cnt_r <= cnt_nxt;
            sar_r <= sar_nxt;
            res_r <= res_nxt;
            done_r <= done_nxt;
        end
    end

    // Accumulator group.
    // Each trial bit is kept when the comparator reports the input above the trial level.
    assign conv_enter = (st_r != atm_pkg::ATM_CONV) && (st_nxt == atm_pkg::ATM_CONV);

    always_comb begin
        approx_nxt = approx_r;
        if (conv_enter) begin
            approx_nxt = 8'h00;
        end else if (bit_step) begin
            approx_nxt = approx_r | (comp_in ? sar_r : 8'h00);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            approx_r <= 8'h00;
        end else begin
            approx_r <= approx_nxt;
        end
    end

    // Tracking control.
    // Standby wins over every mode, so the input stage is quiet in standby or sleep.
    always_comb begin
        track_en = 1'b0;
        if (!standby) begin
            if (!lowpower_track_select) begin
                track_en = (st_r != atm_pkg::ATM_CONV);
            end else if (use_ext_start) begin
                track_en = (st_r == atm_pkg::ATM_IDLE) && !pin_sync_r[1];
            end else begin
                track_en = (st_r == atm_pkg::ATM_TRACK);
            end
        end
    end

    // Status outputs.
    assign busy = (st_r != atm_pkg::ATM_IDLE);
    assign done = done_r;
    assign result = res_r;

    // Mux decode. Reserved positive codes leave every positive enable low.
    assign neg_sel.gnd = chsel_r[7];
    assign neg_sel.pin = chsel_r[6:4];
    assign pos_sel.pin_en = !chsel_r[3];
    assign pos_sel.temp = (chsel_r[3:0] == atm_pkg::POS_TEMP);
    assign pos_sel.vdd = (chsel_r[3:0] == atm_pkg::POS_VDD);
    assign pos_sel.pin = chsel_r[2:0];
endmodule // atm_track_ctrl

// file: core/atm_pkg.sv
// Purpose: Constants and types for the converter track-and-hold and mux control block.
// Assumes: One 100 MHz clock, synchronous active-high reset.
// Notes: Functional notes follow.
package atm_pkg;
    localparam logic [7:0] CHSEL_ADDR = 8'hBB;
    localparam logic [7:0] CHSEL_RESET = 8'h00;
    localparam int TRACK_SAR_CLKS = 3;
    localparam int CONV_SAR_CLKS = 11;
    localparam int RESULT_BITS = 8;
    // SAR clock divider reset value: SAR clock period minus one in system clocks (idle reloads sar_div at once, so the SAR rate follows sar_div).
    localparam logic [7:0] SAR_DIV_RESET = 8'h1F;
    localparam logic [3:0] POS_TEMP = 4'h8;
    localparam logic [3:0] POS_VDD = 4'h9;

    typedef enum logic [1:0] {
        ATM_IDLE = 2'b00,
        ATM_TRACK = 2'b01,
        ATM_CONV = 2'b10
    } atm_state_t;

    typedef struct packed {
        logic gnd;
        logic [2:0] pin;
    } atm_neg_sel_t;

    typedef struct packed {
        logic pin_en;
        logic temp;
        logic vdd;
        logic [2:0] pin;
    } atm_pos_sel_t;
endpackage

// file: bench/atm_track_ctrl_checker.sv
// Purpose: Port-level assertions for the track-and-hold and mux control block.
// Assumes: One clock, synchronous active-high reset.
// Notes: Attached by bind after the module.
module atm_track_ctrl_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic lowpower_track_select,
    input wire logic use_ext_start,
    input wire logic sw_start,
    input wire logic standby,
    input wire logic track_en,
    input wire logic busy,
    input wire logic done,
    input wire atm_pkg::atm_neg_sel_t neg_sel,
    input wire atm_pkg::atm_pos_sel_t pos_sel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_swgo;
        !busy && sw_start && !use_ext_start && !standby;
    endsequence
    a_wr_read: assert property ((sfr_wr && sfr_addr == 8'hBB) ##1 sfr_addr == 8'hBB |-> sfr_rdata == $past(sfr_wdata)) else $error("channel select readback wrong");
    a_unmapped_zero: assert property (sfr_addr != 8'hBB |-> sfr_rdata == 8'h00) else $error("unmapped read not zero");
    a_mux_decode: assert property (sfr_addr == 8'hBB |-> neg_sel == sfr_rdata[7:4] && pos_sel.pin_en == !sfr_rdata[3] && pos_sel.temp == (sfr_rdata[3:0] == 4'h8) && pos_sel.vdd == (sfr_rdata[3:0] == 4'h9)) else $error("mux decode wrong");
    a_idle_tracks: assert property (!lowpower_track_select && !busy && !standby |-> track_en) else $error("idle default mode not tracking");
    a_conv_pause: assert property (s_swgo ##0 !lowpower_track_select |=> busy && !track_en) else $error("tracking during conversion");
    a_lp_track: assert property (s_swgo ##0 lowpower_track_select |=> track_en [*3]) else $error("low-power track interval short");
    a_standby_off: assert property (standby && !busy |-> !track_en) else $error("tracking in standby");
    a_done_pulse: assert property (done |-> !busy ##1 !done) else $error("done not a single pulse");
endmodule // atm_track_ctrl_checker

bind atm_track_ctrl atm_track_ctrl_checker atm_track_ctrl_checker_inst (.*);

// file: bench/atm_pin_model.sv
// Purpose: Outside party driving the external convert-start pin.
// Assumes: Pin idles high; a go pulse asks for one pin-triggered conversion.
// Notes: Low phase is the tracking interval.
module atm_pin_model (
    input wire logic clk,
    input wire logic go,
    output logic pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial pin = 1'b1;
    // Holds the pin low for 300 ns of tracking, then rises to start the conversion.
    always @(posedge clk) if (go) begin
        #1 pin = 1'b0;
        repeat (30) @(posedge clk);
        #1 pin = 1'b1;
    end
endmodule // atm_pin_model

// file: bench/atm_track_ctrl_tb.sv
// Purpose: Self-checking bench for the track-and-hold and mux control block.
// Assumes: Inputs change 1 ns after the rising clock edge.
// Notes: The divider is randomised to keep conversions short.
module atm_track_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, wr = 0, ue = 0, sw = 0, sb = 0, ci = 0, go = 0, lp = 0, te, bz, dn;
    logic [7:0] ad = 8'hBB, wd = 0, dv = 0, rd, res, d;
    wire pin;
    atm_pkg::atm_neg_sel_t ns;
    atm_pkg::atm_pos_sel_t ps;
    int failures = 0, check_count = 0, n;
    always #5 clk = ~clk;
    atm_pin_model atm_pin_model_inst (.clk(clk), .go(go), .pin(pin));
    atm_track_ctrl atm_track_ctrl_inst (.clk(clk), .rst(rst), .sfr_wr(wr), .sfr_addr(ad),
        .sfr_wdata(wd), .sfr_rdata(rd), .lowpower_track_select(lp), .use_ext_start(ue),
        .sw_start(sw), .external_convert_start(pin), .standby(sb), .sar_div(dv), .comp_in(ci),
        .track_en(te), .busy(bz), .done(dn), .result(res), .neg_sel(ns), .pos_sel(ps));
    task chk(input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task wrap_up;
        $display("checks=%0d failures=%0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    function automatic int span(input logic l, input logic [7:0] v);
        return (l ? 14 : 11) * (v + 1);
    endfunction
    task wait_done;
        while (!dn && n < 3000) begin
            @(posedge clk) #1 n++;
            if (n == 2) chk(te, lp);
        end
    endtask
    initial begin
        #200000 failures++;
        wrap_up();
    end
    initial begin
        void'($urandom(32'hcc2d));
        repeat (4) @(posedge clk);
        #1 rst = 0;
        chk(rd, 8'h00);
        for (int i = 0; i < 20; i++) begin
            d = (i < 16) ? {4'($urandom), 4'(i)} : 8'($urandom);
            @(posedge clk) #1 wr = 1;
            ad = (i == 5) ? 8'h3C : 8'hBB;
            wd = d;
            @(posedge clk) #1 wr = 0;
            chk(rd, (i == 5) ? 8'h00 : d);
            ad = 8'hBB;
            if (i != 5) chk(8'(ns), 8'(d[7:4]));
            if (i != 5) chk(8'(ps), 8'({d[3:0] < 8, d[3:0] == 8, d[3:0] == 9, d[2:0]}));
        end
        for (int k = 0; k < 4; k++) begin
            lp = k[0];
            dv = 8'($urandom % 4);
            ci = 1'($urandom);
            @(posedge clk) #1 chk(te, !lp);
            sw = 1;
            repeat (2) @(posedge clk);
            #1 sw = 0;
            n = 1;
            wait_done();
            chk(8'(n), 8'(span(lp, dv)));
            chk(res, {8{ci}});
            @(posedge clk) #1 chk(bz, 0);
        end
        ue = 1;
        lp = 1;
        #20 chk(te, 0);
        go = 1;
        @(posedge clk) #1 go = 0;
        repeat (15) @(posedge clk);
        #1 chk(te, 1);
        n = 2;
        wait_done();
        chk(dn, 1);
        chk(res, {8{ci}});
        ue = 0;
        lp = 0;
        sb = 1;
        sw = 1;
        @(posedge clk) #1 sw = 0;
        repeat (3) @(posedge clk);
        #1 chk({bz, te}, 0);
        wrap_up();
    end
endmodule // atm_track_ctrl_tb
